// file: cbi_bus_master.sv
// CPU system bus transaction sequencer with an Avalon-MM register port
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cbi_defs.svh"

module cbi_bus_master
	import cbi_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Avalon-MM register slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Multiplexed address/data bus, split into in, out and enable
	input wire logic [15:0] mux_addr_data_bus_in,
	output logic [15:0] mux_addr_data_bus_out,
	output logic mux_addr_data_bus_oe_n,
	// Transaction control outputs
	output logic [7:0] segment_number_out,
	output logic [3:0] transaction_status_code,
	output logic address_strobe_n,
	output logic data_strobe_n,
	output logic read_write,
	output logic byte_word,
	output logic normal_system,
	output logic memory_request_n,
	output logic ctl_oe_n,
	// Wait and bus control
	input wire logic wait_n,
	input wire logic bus_request_n,
	output logic bus_grant_ack_n,
	// Interrupt and trap requests
	input wire logic nmi_n,
	input wire logic nonvectored_irq_n,
	input wire logic vectored_irq_n,
	input wire logic segment_trap_n,
	// Resource request lines
	input wire logic resource_req_in_n,
	output logic resource_req_out_n,
	// CPU control
	input wire logic stop_n,
	input wire logic cpu_reset_n
);
	import cbi_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cbi_state_s r_reg; // All flip-flops
	cbi_state_s r_next; // Their next value

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	// Number of cycles a code takes without external waits
	function automatic logic [3:0] base_len(input logic [3:0] code);
		logic [3:0] len;
		len = `CBI_MEM_CYCLES;
		if (code == `CBI_ST_IO_STD || code == `CBI_ST_IO_SPC) begin
			len = `CBI_IO_CYCLES;
		end else if (code[3:2] == 2'b01) begin
			len = `CBI_ACK_CYCLES;
		end
		return len;
	endfunction

	// Decoded fields of the pending command
	logic [3:0] cmd_code; // Status code to issue
	logic no_data; // Refresh or internal: no data strobe, no wait
	logic is_mem; // Memory address on the bus
	logic is_ack; // Interrupt or trap acknowledge
	logic no_addr; // Transaction carries no address
	logic cmd_read; // Effective direction
	logic acc; // Bus access accepted this cycle
	logic go_req; // Software asks for a transaction

	always_comb begin
		cmd_code = r_reg.cmd[`CBI_CMD_CODE_HI:`CBI_CMD_CODE_LO];
		no_data = (cmd_code == `CBI_ST_INTERNAL) || (cmd_code == `CBI_ST_REFRESH);
		is_ack = (cmd_code[3:2] == 2'b01);
		is_mem = cmd_code[3] && (cmd_code != `CBI_ST_EXT_XFER) && (cmd_code != `CBI_ST_RESERVED);
		no_addr = is_ack || (cmd_code == `CBI_ST_EXT_XFER) || (cmd_code == `CBI_ST_INTERNAL);
		cmd_read = r_reg.cmd[`CBI_CMD_READ] || is_ack || (cmd_code == `CBI_ST_INTERNAL);
		acc = (avs_read || avs_write) && !r_reg.ack_wait_n;
		go_req = acc && avs_write && (avs_address == `CBI_OFS_CMD) && avs_byteenable[0]
			&& avs_writedata[`CBI_CMD_GO];
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Outputs are derived from the next state so every pin comes from a flop
	always_comb begin
		r_next = r_reg;

		// Avalon answer: waitrequest drops for exactly one cycle per request
		r_next.ack_wait_n = !((avs_read || avs_write) && r_reg.ack_wait_n);

		// Interrupt inputs: nmi is edge triggered, the others are levels
		r_next.nmi_prev = nmi_n;
		if (r_reg.nmi_prev && !nmi_n) begin
			r_next.nmi_pend = 1'b1;
		end

		// Register reads, latched in the cycle the request is seen
		if ((avs_read || avs_write) && r_reg.ack_wait_n) begin
			case (avs_address)
				`CBI_OFS_CMD: begin
					r_next.readdata = {24'h000000, r_reg.cmd};
				end
				`CBI_OFS_ADDR: begin
					r_next.readdata = {16'h0000, r_reg.addr};
				end
				`CBI_OFS_SEG: begin
					r_next.readdata = {24'h000000, r_reg.seg};
				end
				`CBI_OFS_WDATA: begin
					r_next.readdata = {16'h0000, r_reg.wdata};
				end
				`CBI_OFS_RDATA: begin
					r_next.readdata = {16'h0000, r_reg.rdata};
				end
				`CBI_OFS_STATUS: begin
					// Level requests shown as live pin state
					r_next.readdata = {23'h000000, r_reg.reject, !stop_n, !resource_req_in_n,
						!segment_trap_n, !vectored_irq_n, !nonvectored_irq_n,
						r_reg.nmi_pend, !r_reg.grant_n, r_reg.state != CBI_IDLE};
				end
				`CBI_OFS_RESOUT: begin
					r_next.readdata = {31'h00000000, !r_reg.res_out_n};
				end
				default: begin
					// Unmapped addresses read as zero
					r_next.readdata = 32'h00000000;
				end
			endcase
		end

		// Register writes take effect on the accepting edge
		if (acc && avs_write) begin
			case (avs_address)
				`CBI_OFS_CMD: begin
					// Command is frozen while a transaction runs
					if (avs_byteenable[0] && r_reg.state == CBI_IDLE) begin
						r_next.cmd = {avs_writedata[7:1], 1'b0};
					end
				end
				`CBI_OFS_ADDR: begin
					r_next.addr = merge16(r_reg.addr, avs_writedata, avs_byteenable);
				end
				`CBI_OFS_SEG: begin
					if (avs_byteenable[0]) begin
						r_next.seg = avs_writedata[7:0];
					end
				end
				`CBI_OFS_WDATA: begin
					r_next.wdata = merge16(r_reg.wdata, avs_writedata, avs_byteenable);
				end
				`CBI_OFS_STATUS: begin
					// Write one clears; a new edge in the same cycle wins
					if (avs_byteenable[0] && avs_writedata[`CBI_STA_NMI] && !(r_reg.nmi_prev && !nmi_n)) begin
						r_next.nmi_pend = 1'b0;
					end
					if (avs_byteenable[1] && avs_writedata[`CBI_STA_REJECT]) begin
						r_next.reject = 1'b0;
					end
				end
				`CBI_OFS_RESOUT: begin
					if (avs_byteenable[0]) begin
						r_next.res_out_n = !avs_writedata[0];
					end
				end
				default: begin
					// Writes elsewhere are dropped
				end
			endcase
		end

		// Transaction sequencer
		case (r_reg.state)
			CBI_IDLE: begin
				if (!bus_request_n) begin
					r_next.state = CBI_GRANT;
				end else if (go_req) begin
					if (avs_writedata[`CBI_CMD_CODE_HI:`CBI_CMD_CODE_LO] == `CBI_ST_RESERVED) begin
						r_next.reject = 1'b1;
					end else begin
						r_next.cmd = avs_writedata[7:0];
						r_next.state = CBI_LEAD;
					end
				end
			end
			CBI_LEAD: begin
				// Segment number already out; a bus request still takes priority
				if (!bus_request_n) begin
					r_next.state = CBI_GRANT;
					r_next.cmd[`CBI_CMD_GO] = 1'b0;
				end else if (!(cmd_code == `CBI_ST_PROG_FIRST && !stop_n)) begin
					r_next.state = CBI_ADDR;
				end
			end
			CBI_ADDR: begin
				r_next.state = CBI_DATA;
				r_next.wait_cnt = base_len(cmd_code) - `CBI_BASE_CYCLES;
			end
			CBI_DATA: begin
				if (r_reg.wait_cnt != 4'h0) begin
					r_next.wait_cnt = r_reg.wait_cnt - 4'h1;
				end else if (!wait_n && !no_data) begin
					r_next.state = CBI_DATA;
				end else begin
					r_next.state = CBI_DONE;
					if (cmd_read && !no_data) begin
						r_next.rdata = mux_addr_data_bus_in;
					end
				end
			end
			CBI_DONE: begin
				r_next.state = CBI_IDLE;
				r_next.cmd[`CBI_CMD_GO] = 1'b0;
				r_next.last_byte = r_next.bw;
			end
			CBI_GRANT: begin
				if (bus_request_n) begin
					r_next.state = CBI_IDLE;
				end
			end
			default: begin
				r_next.state = CBI_IDLE;
			end
		endcase

		// Pin values for the next state
		r_next.as_n = 1'b1;
		r_next.ds_n = 1'b1;
		r_next.memory_request_n_n = 1'b1;
		r_next.ad_oe_n = 1'b1;
		r_next.ctl_oe_n = 1'b0;
		r_next.grant_n = 1'b1;
		case (r_next.state)
			CBI_LEAD: begin
				r_next.seg_out = r_next.seg;
			end
			CBI_ADDR: begin
				r_next.as_n = 1'b0;
				r_next.code_out = cmd_code;
				r_next.rw = cmd_read;
				// Refresh keeps the previous size; acknowledge is a word
				r_next.bw = is_ack ? 1'b0 : (cmd_code == `CBI_ST_REFRESH ? r_reg.last_byte
					: r_reg.cmd[`CBI_CMD_BYTE]);
				r_next.ns = (cmd_code[3:2] == 2'b00 && !no_data) || is_ack ? 1'b0 : r_reg.cmd[`CBI_CMD_NORMAL];
				r_next.ad_out = no_addr ? 16'h0000 : r_reg.addr;
				r_next.ad_oe_n = 1'b0;
				r_next.memory_request_n_n = !is_mem;
			end
			CBI_DATA: begin
				r_next.ds_n = no_data;
				r_next.ad_out = r_reg.wdata;
				r_next.ad_oe_n = cmd_read || no_data;
			end
			CBI_GRANT: begin
				r_next.ctl_oe_n = 1'b1;
				r_next.grant_n = 1'b0;
			end
			default: begin
				// Idle and end of transaction: strobes high, bus released
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Either reset source clears everything; both are synchronous
	always_ff @(posedge clock) begin
		if (sys_rst || !cpu_reset_n) begin
			r_reg <= '0;
			r_reg.state <= CBI_IDLE;
			r_reg.ack_wait_n <= 1'b1;
			r_reg.nmi_prev <= 1'b1;
			r_reg.as_n <= 1'b1;
			r_reg.ds_n <= 1'b1;
			r_reg.memory_request_n_n <= 1'b1;
			r_reg.ad_oe_n <= 1'b1;
			r_reg.grant_n <= 1'b1;
			r_reg.rw <= 1'b1;
			// Resource request pin idles high so reset never claims a resource
			r_reg.res_out_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, straight from flops
	// ----------------------------------------------------------------
	assign avs_readdata = r_reg.readdata;
	assign avs_waitrequest = r_reg.ack_wait_n;
	assign mux_addr_data_bus_out = r_reg.ad_out;
	assign mux_addr_data_bus_oe_n = r_reg.ad_oe_n;
	assign segment_number_out = r_reg.seg_out;
	assign transaction_status_code = r_reg.code_out;
	assign address_strobe_n = r_reg.as_n;
	assign data_strobe_n = r_reg.ds_n;
	assign read_write = r_reg.rw;
	assign byte_word = r_reg.bw;
	assign normal_system = r_reg.ns;
	assign memory_request_n = r_reg.memory_request_n_n;
	assign ctl_oe_n = r_reg.ctl_oe_n;
	assign bus_grant_ack_n = r_reg.grant_n;
	assign resource_req_out_n = r_reg.res_out_n;
endmodule

// file: cbi_bus_master_sva.sv
// Port checker for the bus sequencer, bound to its top module
`timescale 1ns/1ps
module cbi_bus_master_sva (
	// Clock and resets
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cpu_reset_n,
	// Watched outputs and inputs
	input wire logic [15:0] mux_addr_data_bus_out,
	input wire logic mux_addr_data_bus_oe_n,
	input wire logic [3:0] transaction_status_code,
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_write,
	input wire logic byte_word,
	input wire logic normal_system,
	input wire logic memory_request_n,
	input wire logic ctl_oe_n,
	input wire logic wait_n,
	input wire logic bus_request_n,
	input wire logic bus_grant_ack_n
);
	// Either reset input puts the sequencer back to idle
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst || !cpu_reset_n);
	// ----------------------------------------
	// Transaction framing
	// ----------------------------------------
	a_code_reserved: assert property (!address_strobe_n |-> transaction_status_code != 4'hF)
		else $error("reserved status code issued");
	a_strobe_order: assert property ($fell(data_strobe_n) |-> !$past(address_strobe_n) && address_strobe_n)
		else $error("data strobe not after address strobe");
	a_no_data_strobe: assert property ((!address_strobe_n && transaction_status_code < 4'h2) |=> data_strobe_n [*4])
		else $error("data strobe in a no-data transaction");
	a_memory_request_n_memory: assert property ($fell(address_strobe_n) |->
		memory_request_n == !(transaction_status_code inside {[4'h8:4'hD]}))
		else $error("memory request does not match code");
	a_ack_fields: assert property ((!address_strobe_n && transaction_status_code inside {[4'h4:4'h7]}) |->
		read_write && !byte_word && !normal_system)
		else $error("acknowledge not system word read");
	// ----------------------------------------
	// Data phase and wait
	// ----------------------------------------
	a_read_release: assert property ((!data_strobe_n && read_write) |-> mux_addr_data_bus_oe_n)
		else $error("bus driven during read data phase");
	a_write_drive: assert property ((!data_strobe_n && !read_write) |-> !mux_addr_data_bus_oe_n)
		else $error("write data not driven");
	a_wait_extend: assert property ((!data_strobe_n && !wait_n && transaction_status_code >= 4'h8) |=> !data_strobe_n)
		else $error("low wait did not extend");
	a_mem_length: assert property (($fell(data_strobe_n) && wait_n && transaction_status_code >= 4'h8) |=> data_strobe_n)
		else $error("memory data phase not one cycle");
	a_io_length: assert property (($fell(data_strobe_n) && transaction_status_code inside {4'h2, 4'h3}) |=> !data_strobe_n)
		else $error("io data phase too short");
	// ----------------------------------------
	// Bus hand-over
	// ----------------------------------------
	a_grant_float: assert property (!bus_grant_ack_n |-> ctl_oe_n && mux_addr_data_bus_oe_n)
		else $error("outputs driven while granted");
	a_grant_return: assert property ((!bus_grant_ack_n && bus_request_n) |=> bus_grant_ack_n)
		else $error("grant held after request dropped");
endmodule

bind cbi_bus_master cbi_bus_master_sva chk_u (.clock, .sys_rst, .cpu_reset_n, .mux_addr_data_bus_out,
	.mux_addr_data_bus_oe_n, .transaction_status_code, .address_strobe_n, .data_strobe_n, .read_write,
	.byte_word, .normal_system, .memory_request_n, .ctl_oe_n, .wait_n, .bus_request_n, .bus_grant_ack_n);

// file: cbi_bus_master_tb_top.sv
// Self-checking bench for the bus sequencer
`timescale 1ns/1ps
`include "cbi_defs.svh"
module cbi_bus_master_tb_top;
	import cbi_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q;
	logic [3:0] avs_byteenable = 4'hF, transaction_status_code, waits = 4'h0;
	logic [15:0] mux_addr_data_bus_in, mux_addr_data_bus_out, reply = 16'h0;
	logic [7:0] segment_number_out;
	logic avs_waitrequest, mux_addr_data_bus_oe_n, address_strobe_n, data_strobe_n, read_write, byte_word;
	logic normal_system, memory_request_n, ctl_oe_n, wait_n, bus_grant_ack_n, resource_req_out_n;
	logic bus_request_n = 1'b1, nmi_n = 1'b1, nonvectored_irq_n = 1'b1, vectored_irq_n = 1'b1;
	logic segment_trap_n = 1'b1, resource_req_in_n = 1'b1, stop_n = 1'b1, cpu_reset_n = 1'b1;
	int err_count = 0;
	int total_checks = 0;
	// Clock at 25 MHz
	always #20 clock = ~clock;
	cbi_bus_master dut_u (.clock, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .mux_addr_data_bus_in, .mux_addr_data_bus_out,
		.mux_addr_data_bus_oe_n, .segment_number_out, .transaction_status_code, .address_strobe_n,
		.data_strobe_n, .read_write, .byte_word, .normal_system, .memory_request_n, .ctl_oe_n, .wait_n,
		.bus_request_n, .bus_grant_ack_n, .nmi_n, .nonvectored_irq_n, .vectored_irq_n, .segment_trap_n,
		.resource_req_in_n, .resource_req_out_n, .stop_n, .cpu_reset_n);
	cbi_far_side far_u (.clock, .bus_out(mux_addr_data_bus_out), .bus_oe_n(mux_addr_data_bus_oe_n),
		.data_strobe_n, .read_write, .reply_word(reply), .wait_cycles(waits), .bus_in(mux_addr_data_bus_in),
		.wait_n);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Compare with four-state equality so unknowns never match
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One Avalon access: held until waitrequest is seen low
	task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			test_done();
		end
	endtask
	task automatic rd(input logic [4:0] a);
		av_xfer(1'b0, a, 32'h0);
	endtask
	// Issue one transaction of a code and watch the bus for 20 cycles
	task automatic run_code(input logic [3:0] c);
		logic [15:0] a;
		logic [7:0] sp;
		int nds;
		int nas;
		a = 16'h1230 | c;
		nds = 0;
		nas = 0;
		reply <= 16'h5A00 | c;
		waits <= (c == 4'h9) ? 4'h2 : (c == 4'hC) ? 4'h1 : 4'h0;
		av_xfer(1'b1, `CBI_OFS_ADDR, {16'h0, a});
		av_xfer(1'b1, `CBI_OFS_SEG, {24'h0, 4'h6, c});
		av_xfer(1'b1, `CBI_OFS_WDATA, {16'h0, 4'hC, c, 4'hC, c});
		av_xfer(1'b1, `CBI_OFS_CMD, {24'h0, 1'b1, c[1], c[0], c, 1'b1});
		for (int i = 0; i < 20; i++) begin
			@(posedge clock);
			if (!data_strobe_n && !read_write) check(mux_addr_data_bus_out, {4'hC, c, 4'hC, c});
			if (!address_strobe_n) begin
				nas++;
				check(transaction_status_code, c);
				check(memory_request_n, !(c >= 4'h8 && c <= 4'hD));
				check(mux_addr_data_bus_out, (c inside {0, 4, 5, 6, 7, 14}) ? 16'h0 : a);
				if (c >= 4'h8 && c <= 4'hD) check(sp, {4'h6, c});
				if (c > 4'h1) check({read_write, byte_word, normal_system},
					(c >= 4'h4 && c <= 4'h7) ? 3'b100 : {c[0], c[1], c > 4'h7});
			end
			if (!data_strobe_n) nds++;
			sp = segment_number_out;
		end
		check(nas, (c == 4'hF) ? 0 : 1);
		check(nds, (c == 4'hF || c < 4'h2) ? 0 : (c < 4'h4) ? 2 : (c < 4'h8) ? 6 : 1 + waits);
		if (c > 4'h1 && c != 4'hF && (c[0] || c inside {[4:7]})) begin
			rd(`CBI_OFS_RDATA);
			check(rd_q[15:0], reply);
		end
		rd(`CBI_OFS_STATUS);
		check(rd_q & 32'h101, (c == 4'hF) ? 32'h100 : 32'h0);
		if (c == 4'hF) av_xfer(1'b1, `CBI_OFS_STATUS, 32'h100);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		for (int c = 0; c < 16; c++) run_code(4'(c));
		// Bus hand-over and return
		bus_request_n <= 1'b0;
		for (int n = 0; n < 10 && bus_grant_ack_n !== 1'b0; n++) @(posedge clock);
		check(bus_grant_ack_n, 0);
		check(ctl_oe_n, 1);
		rd(`CBI_OFS_STATUS);
		check(rd_q[1], 1);
		bus_request_n <= 1'b1;
		repeat (2) @(posedge clock);
		check(bus_grant_ack_n, 1);
		// Level requests, resource input and stop seen in status
		{nonvectored_irq_n, vectored_irq_n, segment_trap_n, resource_req_in_n, stop_n} <= 5'h00;
		repeat (3) @(posedge clock);
		rd(`CBI_OFS_STATUS);
		check(rd_q[7:3], 5'h1F);
		{nonvectored_irq_n, vectored_irq_n, segment_trap_n, resource_req_in_n, stop_n} <= 5'h1F;
		// Edge request: a held low level must not set it again after clearing
		nmi_n <= 1'b0;
		repeat (3) @(posedge clock);
		rd(`CBI_OFS_STATUS);
		check(rd_q[2], 1);
		av_xfer(1'b1, `CBI_OFS_STATUS, 32'h4);
		rd(`CBI_OFS_STATUS);
		check(rd_q[2], 0);
		nmi_n <= 1'b1;
		// Stop holds a first-word fetch in its lead cycle until released
		stop_n <= 1'b0;
		av_xfer(1'b1, `CBI_OFS_CMD, {24'h0, 8'hBB});
		repeat (4) begin
			@(posedge clock);
			check(address_strobe_n, 1);
		end
		rd(`CBI_OFS_STATUS);
		check(rd_q[0], 1);
		stop_n <= 1'b1;
		for (int n = 0; n < 10 && address_strobe_n !== 1'b0; n++) @(posedge clock);
		check(address_strobe_n, 0);
		check(transaction_status_code, 4'hD);
		repeat (10) @(posedge clock);
		rd(`CBI_OFS_STATUS);
		check(rd_q[0], 0);
		// Resource request output and an unmapped address
		av_xfer(1'b1, `CBI_OFS_RESOUT, 32'h1);
		repeat (2) @(posedge clock);
		check(resource_req_out_n, 0);
		rd(5'h1C);
		check(rd_q, 32'h0);
		// Reset through the pin, then a transaction again
		cpu_reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		check({address_strobe_n, data_strobe_n, memory_request_n, bus_grant_ack_n, resource_req_out_n}, 5'h1F);
		cpu_reset_n <= 1'b1;
		run_code(4'h8);
		test_done();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		test_done();
	end
endmodule

// file: cbi_defs.svh
// Constants for the CPU system bus interface: offsets, fields, reset values, counts
`ifndef CBI_DEFS_SVH
`define CBI_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CBI_OFS_CMD 5'h00
`define CBI_OFS_ADDR 5'h04
`define CBI_OFS_SEG 5'h08
`define CBI_OFS_WDATA 5'h0C
`define CBI_OFS_RDATA 5'h10
`define CBI_OFS_STATUS 5'h14
`define CBI_OFS_RESOUT 5'h18

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define CBI_CMD_GO 0
`define CBI_CMD_CODE_LO 1
`define CBI_CMD_CODE_HI 4
`define CBI_CMD_READ 5
`define CBI_CMD_BYTE 6
`define CBI_CMD_NORMAL 7

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define CBI_STA_BUSY 0
`define CBI_STA_GRANT 1
`define CBI_STA_NMI 2
`define CBI_STA_NVI 3
`define CBI_STA_VI 4
`define CBI_STA_SEGMENT_TRAP_N 5
`define CBI_STA_RESIN 6
`define CBI_STA_STOP 7
`define CBI_STA_REJECT 8

// ----------------------------------------------------------------
// Transaction status codes
// ----------------------------------------------------------------
`define CBI_ST_INTERNAL 4'h0
`define CBI_ST_REFRESH 4'h1
`define CBI_ST_IO_STD 4'h2
`define CBI_ST_IO_SPC 4'h3
`define CBI_ST_ACK_SEGMENT_TRAP_N 4'h4
`define CBI_ST_ACK_NMI 4'h5
`define CBI_ST_ACK_NVI 4'h6
`define CBI_ST_ACK_VI 4'h7
`define CBI_ST_MEM_DATA 4'h8
`define CBI_ST_MEM_STACK 4'h9
`define CBI_ST_MEM_DATA_EXT 4'hA
`define CBI_ST_MEM_STACK_EXT 4'hB
`define CBI_ST_PROG 4'hC
`define CBI_ST_PROG_FIRST 4'hD
`define CBI_ST_EXT_XFER 4'hE
`define CBI_ST_RESERVED 4'hF

// ----------------------------------------------------------------
// Timing: transaction lengths in clocks before any external wait
// ----------------------------------------------------------------
`define CBI_MEM_CYCLES 4'h3
`define CBI_IO_CYCLES 4'h4
`define CBI_ACK_CYCLES 4'h8
`define CBI_BASE_CYCLES 4'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CBI_RST_CMD 8'h00
`define CBI_RST_WORD 16'h0000
`define CBI_RST_SEG 8'h00

`endif

// file: cbi_far_side.sv
// Responder model: memory, peripherals and acknowledging devices on the bus
`timescale 1ns/1ps
module cbi_far_side (
	// Clock
	input wire logic clock,
	// Bus as seen by the responder
	input wire logic [15:0] bus_out,
	input wire logic bus_oe_n,
	input wire logic data_strobe_n,
	input wire logic read_write,
	// Bench control
	input wire logic [15:0] reply_word,
	input wire logic [3:0] wait_cycles,
	// Responder outputs
	output logic [15:0] bus_in,
	output logic wait_n
);
	logic [15:0] last_reg = 16'h0000; // Last wire level
	logic [3:0] cnt_reg = 4'h0; // Strobe cycles so far
	// Wire level; a released bus drifts so stale data never looks valid
	always_comb begin
		if (!bus_oe_n) begin
			bus_in = bus_out;
		end else if (!data_strobe_n && read_write) begin
			bus_in = reply_word;
		end else begin
			bus_in = ~last_reg;
		end
	end
	// Wait low for a set count of strobe cycles; derived from registers only
	assign wait_n = !(!data_strobe_n && cnt_reg < wait_cycles);
	// Track wire and strobe length
	always_ff @(posedge clock) begin
		last_reg <= bus_in;
		cnt_reg <= data_strobe_n ? 4'h0 : cnt_reg + 4'h1;
	end
endmodule

// file: cbi_pkg.sv
// Types for the CPU system bus interface: state encoding and the state record
package cbi_pkg;
	`include "cbi_defs.svh"

	// Transaction sequencer states, one-hot
	typedef enum logic [5:0] {
		CBI_IDLE = 6'h01,
		CBI_LEAD = 6'h02,
		CBI_ADDR = 6'h04,
		CBI_DATA = 6'h08,
		CBI_DONE = 6'h10,
		CBI_GRANT = 6'h20
	} cbi_state_e;

	// Every flip-flop of the block
	typedef struct packed {
		cbi_state_e state;
		logic [7:0] cmd;
		logic [15:0] addr;
		logic [7:0] seg;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [3:0] wait_cnt;
		logic nmi_pend;
		logic nmi_prev;
		logic reject;
		logic res_out_n;
		logic last_byte;
		logic ack_wait_n;
		logic [31:0] readdata;
		logic [15:0] ad_out;
		logic ad_oe_n;
		logic [7:0] seg_out;
		logic [3:0] code_out;
		logic as_n;
		logic ds_n;
		logic rw;
		logic bw;
		logic ns;
		logic memory_request_n_n;
		logic ctl_oe_n;
		logic grant_n;
	} cbi_state_s;
endpackage
